// File: design/overtemp_pkg.sv
// package: constants and carrier types for the over-temperature trip block
package overtemp_pkg;
  localparam int        TEMP_W        = 8;
  // trip level in degrees celsius, compared against the sensor code
  localparam logic [7:0] TRIP_LEVEL_C = 8'h87;
  localparam logic [31:0] BOOT_VECTOR = 32'hfffffff0;
  localparam logic       PIN_ACTIVE   = 1'b0;
  localparam logic       PIN_IDLE     = 1'b1;

  typedef struct packed {
    logic             valid;
    logic [TEMP_W-1:0] temp_c;
  } sensor_t;

  typedef struct packed {
    logic        run;
    logic [31:0] fetch_pc;
  } core_ctl_t;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_RUN   = 2'b01,
    ST_SHUT  = 2'b10
  } trip_state_t;
endpackage : overtemp_pkg

// File: design/overtemp_compare.sv
// module: threshold comparator on the sensor reading
`timescale 1ns/1ps
module overtemp_compare (
  input  wire logic                clk_in,
  input  wire logic                rstn_in,
  input  wire overtemp_pkg::sensor_t sensor_in,
  output logic                     hot_out
);
  import overtemp_pkg::*;

  function automatic logic at_or_above(input logic [TEMP_W-1:0] t);
    return t >= TRIP_LEVEL_C;
  endfunction : at_or_above

  // registered so the latch sees a clean, single-cycle-delayed level
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hot_out <= 1'b0;
    end else begin
      hot_out <= sensor_in.valid && at_or_above(sensor_in.temp_c); // RQ1
    end
  end
endmodule : overtemp_compare

// File: design/thermal_trip_shutdown.sv
// module: latched over-temperature trip, clock gate and halt control
//
// Contract
// RQ1 - the trip output asserts when the sensor reads at or above the trip level.
// RQ2 - while tripped the core clocks are gated off and execution halts.
// RQ3 - once set the trip latch holds even after the temperature falls.
// RQ4 - system reset clears the latch and releases the output even when hot.
// RQ5 - after reset execution starts at the boot vector and trips again if hot.
// RQ6 - the platform removes power as soon as it sees the trip output active.
// RQ7 - the trip output is active low and driven low only while tripped.
`timescale 1ns/1ps
module thermal_trip_shutdown (
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  input  wire overtemp_pkg::sensor_t   sensor_in,
  output logic                         overtemp_trip_n_out,
  output logic                         overtemp_trip_oe_out,
  output logic                         core_clk_en_out,
  output overtemp_pkg::core_ctl_t      core_ctl_out
);
  import overtemp_pkg::*;

  // ----------------------------------------------------------------
  // sensor threshold
  // ----------------------------------------------------------------
  logic        hot;
  trip_state_t state;
  trip_state_t next_state;

  overtemp_compare u_compare (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .sensor_in (sensor_in),
    .hot_out   (hot)
  );

  // ----------------------------------------------------------------
  // trip state
  // ----------------------------------------------------------------
  // the only way out of shutdown is reset; cooling is ignored on purpose
  always_comb begin
    next_state = state;
    case (state)
      ST_BOOT: begin
        next_state = hot ? ST_SHUT : ST_RUN; // RQ5
      end
      ST_RUN: begin
        if (hot) begin
          next_state = ST_SHUT; // RQ1
        end
      end
      ST_SHUT: begin
        next_state = ST_SHUT; // RQ3
      end
      default: begin
        next_state = ST_SHUT;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_BOOT; // RQ4
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the pin, its enable and the clock gate decode the state flop directly, so the pin and the
  // clock gate can never disagree by a cycle
  logic tripped;
  assign tripped = (state == ST_SHUT);

  // open-drain style: pin pulled high outside, driven only while tripped
  assign overtemp_trip_n_out  = tripped ? PIN_ACTIVE : PIN_IDLE; // RQ7
  assign overtemp_trip_oe_out = tripped; // RQ7
  assign core_clk_en_out      = !tripped; // RQ2

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_ctl_out.run      <= 1'b0;
      core_ctl_out.fetch_pc <= BOOT_VECTOR; // RQ5
    end else begin
      core_ctl_out.run      <= (next_state == ST_RUN); // RQ2
      core_ctl_out.fetch_pc <= BOOT_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence hot_seen_s;
    sensor_in.valid && (sensor_in.temp_c >= TRIP_LEVEL_C);
  endsequence

  sequence trip_active_s;
    !overtemp_trip_n_out && overtemp_trip_oe_out;
  endsequence

  sequence pin_idle_s;
    overtemp_trip_n_out && !overtemp_trip_oe_out;
  endsequence

  sequence run_cold_s;
    (state == ST_RUN) && !hot;
  endsequence

  // the first low edge may still meet an unknown state at power-up, so
  // the reset check starts from the second low edge
  sequence reset_held_s;
    !rstn_in ##1 !rstn_in;
  endsequence

  sequence boot_release_s;
    $rose(rstn_in);
  endsequence

  sequence boot_hot_s;
    boot_release_s ##1 hot;
  endsequence

  trip_on_hot_a: assert property ( // RQ1
    @(posedge clk_in) disable iff (!rstn_in)
    hot_seen_s |-> ##[1:2] trip_active_s)
    else $error("trip output not asserted after hot reading");

  no_false_trip_a: assert property ( // RQ1
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(tripped) |-> $past(hot))
    else $error("trip asserted without a hot reading");

  clock_gated_a: assert property ( // RQ2
    @(posedge clk_in) disable iff (!rstn_in)
    hot |=> !core_clk_en_out)
    else $error("core clock running after hot reading");

  halt_exec_a: assert property ( // RQ2
    @(posedge clk_in) disable iff (!rstn_in)
    trip_active_s |=> !core_ctl_out.run)
    else $error("execution continues after trip");

  trip_latched_a: assert property ( // RQ3
    @(posedge clk_in) disable iff (!rstn_in)
    trip_active_s |=> trip_active_s [*8])
    else $error("trip latch released without reset");

  boot_vector_a: assert property ( // RQ5
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(core_ctl_out.run) |-> core_ctl_out.fetch_pc == BOOT_VECTOR)
    else $error("execution did not start at boot vector");

  reset_release_a: assert property ( // RQ4
    @(posedge clk_in)
    boot_release_s |-> pin_idle_s)
    else $error("trip output still active after reset");

  pin_idle_a: assert property ( // RQ7
    @(posedge clk_in) disable iff (!rstn_in)
    core_clk_en_out |-> pin_idle_s)
    else $error("trip pin driven while not tripped");

  pin_low_oe_a: assert property ( // RQ7
    @(posedge clk_in) disable iff (!rstn_in)
    !overtemp_trip_n_out |-> overtemp_trip_oe_out)
    else $error("trip pin low without its driver enabled");

  // ----------------------------------------------------------------
  // checks: sensing and halt
  // ----------------------------------------------------------------
  invalid_ignored_a: assert property ( // RQ1
    @(posedge clk_in) disable iff (!rstn_in)
    !sensor_in.valid |=> !hot)
    else $error("invalid reading counted as hot");

  cold_keeps_run_a: assert property ( // RQ1
    @(posedge clk_in) disable iff (!rstn_in)
    run_cold_s |=> core_clk_en_out && core_ctl_out.run)
    else $error("core stopped without a hot reading");

  hot_halts_run_a: assert property ( // RQ2
    @(posedge clk_in) disable iff (!rstn_in)
    hot |=> !core_ctl_out.run)
    else $error("execution not halted after hot reading");

  run_needs_clock_a: assert property ( // RQ2
    @(posedge clk_in) disable iff (!rstn_in)
    core_ctl_out.run |-> core_clk_en_out)
    else $error("core running with its clock gated");

  // ----------------------------------------------------------------
  // checks: latch, reset and boot
  // ----------------------------------------------------------------
  // every cycle, not only a window of eight after the trip
  shut_no_exit_a: assert property ( // RQ3
    @(posedge clk_in) disable iff (!rstn_in)
    tripped |=> tripped)
    else $error("shutdown left without reset");

  reset_clears_a: assert property ( // RQ4
    @(posedge clk_in)
    reset_held_s |-> overtemp_trip_n_out && !overtemp_trip_oe_out &&
      core_clk_en_out && !core_ctl_out.run)
    else $error("reset did not clear the trip outputs");

  boot_runs_a: assert property ( // RQ5
    @(posedge clk_in) disable iff (!rstn_in)
    boot_release_s |=> core_clk_en_out && core_ctl_out.run &&
      core_ctl_out.fetch_pc == BOOT_VECTOR)
    else $error("core not running from boot vector after reset");

  boot_one_cycle_a: assert property ( // RQ5
    @(posedge clk_in) disable iff (!rstn_in)
    (state == ST_BOOT) |=> (state != ST_BOOT))
    else $error("boot state held for more than one cycle");

  retrip_hot_a: assert property ( // RQ5
    @(posedge clk_in) disable iff (!rstn_in)
    boot_hot_s |=> trip_active_s)
    else $error("no trip after reset while still hot");
endmodule : thermal_trip_shutdown

// File: verification/power_ctl_model.sv
// platform power control model watching the trip wire
`timescale 1ns/1ps
module power_ctl_model (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic trip_wire_in,
  output logic      power_off_out
);
  // cut supply on the first low level; only a platform reset restores it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) power_off_out <= 1'b0;
    else if (!trip_wire_in) power_off_out <= 1'b1;
  end
endmodule : power_ctl_model

// File: verification/tb.sv
// self-checking bench for the over-temperature trip block
`timescale 1ns/1ps
module tb;
  import overtemp_pkg::*;
  logic      clk_in = 1'b0;
  logic      rstn_in = 1'b0;
  sensor_t   sensor_in = '0;
  logic      trip_n, oe, clk_en, pwr_off, trip_wire;
  core_ctl_t ctl;
  int        miscompares = 0;
  int        checks = 0;
  int        cycles = 0;
  // status word: trip_n, oe, clk_en, run, power off
  wire [4:0] st = {trip_n, oe, clk_en, ctl.run, pwr_off};
  initial forever #25 clk_in = ~clk_in;
  // open drain with pull-up
  assign trip_wire = oe ? 1'b0 : 1'b1;
  thermal_trip_shutdown u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .sensor_in(sensor_in), .overtemp_trip_n_out(trip_n),
    .overtemp_trip_oe_out(oe), .core_clk_en_out(clk_en),
    .core_ctl_out(ctl));
  power_ctl_model u_pwr (.clk_in(clk_in), .rstn_in(rstn_in),
    .trip_wire_in(trip_wire), .power_off_out(pwr_off));
  task automatic edges(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : edges
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic t_cold();
    sensor_in = '{1'b0, 8'hff};
    edges(3);
    chk(st, 5'b10110);
    sensor_in = '{1'b1, 8'h86};
    edges(3);
    chk(st, 5'b10110);
    $display("cold done");
  endtask : t_cold
  task automatic t_trip();
    sensor_in = '{1'b1, 8'h87};
    edges(1);
    chk(st, 5'b10110);
    edges(1);
    chk(st, 5'b01000);
    edges(1);
    chk(st, 5'b01001);
    chk(trip_wire, 1'b0);
    sensor_in = '{1'b1, 8'h00};
    edges(4);
    chk(st, 5'b01001);
    $display("trip done");
  endtask : t_trip
  task automatic t_reset();
    sensor_in = '{1'b1, 8'hff};
    rstn_in = 1'b0;
    #1;
    chk(st, 5'b10100);
    edges(2);
    chk(st, 5'b10100);
    rstn_in = 1'b1;
    edges(1);
    chk(st, 5'b10110);
    chk(ctl.fetch_pc, BOOT_VECTOR);
    edges(1);
    chk(st, 5'b01000);
    edges(1);
    chk(st, 5'b01001);
    $display("reset done");
  endtask : t_reset
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // hang guard: the whole run needs well under a hundred cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    edges(16);
    rstn_in = 1'b1;
    edges(1);
    t_cold();
    t_trip();
    t_reset();
    wrap_up();
  end
endmodule : tb
